// ---- design/npiu_pkg.sv ----
// shared constants of the nested priority interrupt unit
// assumes a 32-bit apb slave with byte addresses on word boundaries
package npiu_pkg;
	localparam int          NUM_SRC    = 6;
	localparam int          NUM_LVL    = 4;
	localparam int          ID_W       = 3;
	localparam int          LVL_W      = 2;
	localparam int          ADDR_W     = 8;
	// source index, which is also the poll order inside a level
	localparam int          SRC_EXT0   = 0;
	localparam int          SRC_CNT0   = 1;
	localparam int          SRC_EXT1   = 2;
	localparam int          SRC_CNT1   = 3;
	localparam int          SRC_UART   = 4;
	localparam int          SRC_CNT2   = 5;
	// register byte offsets
	localparam logic [7:0]  OFS_CTRL   = 8'h00;
	localparam logic [7:0]  OFS_FLAGS  = 8'h04;
	localparam logic [7:0]  OFS_MASK   = 8'h08;
	localparam logic [7:0]  OFS_LVLLO  = 8'h0C;
	localparam logic [7:0]  OFS_LVLHI  = 8'h10;
	localparam logic [7:0]  OFS_SERV   = 8'h14;
	localparam logic [7:0]  OFS_ISTAT  = 8'h18;
	localparam logic [7:0]  OFS_IMASK  = 8'h1C;
	// control register fields
	localparam int          CTL_EDGE0  = 0;
	localparam int          CTL_EDGE1  = 1;
	// flag register fields
	localparam int          FLG_EXT0   = 0;
	localparam int          FLG_CNT0   = 1;
	localparam int          FLG_EXT1   = 2;
	localparam int          FLG_CNT1   = 3;
	localparam int          FLG_RX     = 4;
	localparam int          FLG_TX     = 5;
	localparam int          FLG_C2OV   = 6;
	localparam int          FLG_C2EX   = 7;
	localparam int          FLG_W      = 8;
	// source mask register global bit
	localparam int          MSK_GLOBAL = 7;
	// event status fields
	localparam int          EV_CALL    = 0;
	localparam int          EV_RET     = 1;
	localparam int          EV_W       = 2;
	// reset values
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [1:0]  RST_CTRL   = 2'h0;
	localparam logic [3:0]  RST_SERV   = 4'h0;
	localparam logic [1:0]  RST_EV     = 2'h0;
	localparam logic [2:0]  RST_ID     = 3'h0;
	localparam logic [1:0]  RST_LVL    = 2'h0;
	localparam logic [31:0] RD_ZERO    = 32'h00000000;
endpackage

// ---- design/npiu_arb_if.sv ----
// carrier between the unit top and its priority resolver
// assumes one clock; all signals are combinational views
`timescale 1ns/10ps
interface npiu_arb_if;
	import npiu_pkg::*;
	logic [NUM_SRC-1:0]       active;
	logic [NUM_SRC*LVL_W-1:0] level;
	logic [NUM_LVL-1:0]       in_service;
	logic                     grant_valid;
	logic [ID_W-1:0]          grant_id;
	logic [LVL_W-1:0]         grant_level;
	modport resolver (input active, input level, input in_service,
		output grant_valid, output grant_id, output grant_level);
	modport owner (output active, output level, output in_service,
		input grant_valid, input grant_id, input grant_level);
endinterface

// ---- design/npiu_ext_line.sv ----
// synchroniser and falling edge detector for one external request pin
// assumes the pin is asynchronous to pclk and active low
`timescale 1ns/10ps
module npiu_ext_line (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic line_n,
	output logic      asserted,
	output logic      fall
);
	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	// pins idle high, so reset to the idle level to avoid a false edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
			prev_reg <= 1'b1;
		end else begin
			meta_reg <= line_n;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign asserted = ~sync_reg;
	assign fall     = prev_reg & ~sync_reg;
endmodule

// ---- design/npiu_resolver.sv ----
// priority resolver: level first, then fixed poll order
// assumes inputs are already masked samples
`timescale 1ns/10ps
module npiu_resolver (
	npiu_arb_if.resolver arb
);
	import npiu_pkg::*;
	logic             found;
	logic [ID_W-1:0]  best_id;
	logic [LVL_W-1:0] best_lvl;
	logic [LVL_W-1:0] srv_top;
	logic             srv_any;
	logic [LVL_W-1:0] lv;

	// walk sources from the end so the lowest index wins a tie
	always_comb begin
		found    = 1'b0;
		best_id  = RST_ID;
		best_lvl = RST_LVL;
		lv       = RST_LVL;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			lv = arb.level[i*LVL_W +: LVL_W];
			if (arb.active[i] && (!found || lv >= best_lvl)) begin
				found    = 1'b1;
				best_id  = ID_W'(i);
				best_lvl = lv;
			end
		end
	end

	// highest level now in service
	always_comb begin
		srv_any = 1'b0;
		srv_top = RST_LVL;
		for (int l = 0; l < NUM_LVL; l++) begin
			if (arb.in_service[l]) begin
				srv_any = 1'b1;
				srv_top = LVL_W'(l);
			end
		end
	end

	// strictly higher level only; level 3 in service blocks all
	assign arb.grant_valid = found && (!srv_any || best_lvl > srv_top);
	assign arb.grant_id    = best_id;
	assign arb.grant_level = best_lvl;
endmodule

// ---- design/npiu_top.sv ----
// nested priority interrupt unit: flags, masks, levels, vector calls, apb
// assumes sample_phase pulses once per machine cycle; core inputs share pclk
`timescale 1ns/10ps

// How it works
// - six request sources: two pins, two counters, serial port, third counter
// - each pin pending flag is level or edge driven by its select bit
// - edge driven pin flag is cleared when its call is issued
// - level driven pin flag follows the pin; source removes it
// - counter zero and one flags set on rollover, cleared on their call
// - serial request is rx or tx done; software clears both
// - software may set or clear every flag like hardware does
// - each source has its own mask bit
// - global mask bit low blocks every source
// - each source gets one of four levels from low and high bits
// - only a strictly higher level pre-empts a running handler
// - a level three handler is never pre-empted
// - among simultaneous requests the higher level wins
// - equal levels resolve by order ext0, cnt0, ext1, cnt1, serial
// - third counter source is last in the poll order
// - flags sampled at sample_phase and polled at the next one
// - call withheld if blocked level, not last cycle, return or mask write
// - a blocked request is not remembered once it goes away
module npiu_top
	import npiu_pkg::*;
(
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [npiu_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic                     ext_line_zero_n,
	input  wire logic                     ext_line_one_n,
	input  wire logic                     cnt0_rollover,
	input  wire logic                     cnt1_rollover,
	input  wire logic                     uart_rx_set,
	input  wire logic                     uart_tx_set,
	input  wire logic                     cnt2_overflow_set,
	input  wire logic                     cnt2_external_set,
	input  wire logic                     sample_phase,
	input  wire logic                     last_cycle,
	input  wire logic                     return_from_handler,
	input  wire logic                     mask_write_inst,
	output logic                          hw_vector_call,
	output logic      [npiu_pkg::ID_W-1:0]   vector_id,
	output logic      [npiu_pkg::LVL_W-1:0]  vector_level,
	output logic                          irq
);
	import npiu_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// state
	logic [1:0]         counter_control_reg;
	logic [FLG_W-1:0]   flags_reg;
	logic [FLG_W-1:0]   flags_next;
	logic [7:0]         source_mask_reg;
	logic [7:0]         level_low_reg;
	logic [7:0]         level_high_reg;
	logic [NUM_LVL-1:0] in_service_reg;
	logic [NUM_LVL-1:0] in_service_next;
	logic [NUM_SRC-1:0] sample_reg;
	logic               sample_valid_reg;
	logic               call_reg;
	logic [ID_W-1:0]    id_reg;
	logic [LVL_W-1:0]   lvl_reg;
	logic [EV_W-1:0]    ev_status_reg;
	logic [EV_W-1:0]    ev_status_next;
	logic [EV_W-1:0]    ev_mask_reg;

	// carrier to the resolver, declared early since the flag logic reads the grant
	npiu_arb_if arb ();

	////////////////////////////////////////////////////////////////////////
	// apb decode
	logic        acc;
	logic        wr;
	logic        rd;
	logic        hit_ctrl;
	logic        hit_flags;
	logic        hit_mask;
	logic        hit_lvllo;
	logic        hit_lvlhi;
	logic        hit_serv;
	logic        hit_istat;
	logic        hit_imask;
	logic        mapped;
	logic [31:0] rd_mux;

	assign acc       = psel & penable;
	assign wr        = acc & pwrite;
	assign rd        = acc & ~pwrite;
	assign hit_ctrl  = (paddr == OFS_CTRL);
	assign hit_flags = (paddr == OFS_FLAGS);
	assign hit_mask  = (paddr == OFS_MASK);
	assign hit_lvllo = (paddr == OFS_LVLLO);
	assign hit_lvlhi = (paddr == OFS_LVLHI);
	assign hit_serv  = (paddr == OFS_SERV);
	assign hit_istat = (paddr == OFS_ISTAT);
	assign hit_imask = (paddr == OFS_IMASK);
	assign mapped    = hit_ctrl | hit_flags | hit_mask | hit_lvllo | hit_lvlhi
		| hit_serv | hit_istat | hit_imask;

	// zero wait states; unmapped or misaligned addresses answer with an error
	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;

	assign rd_mux =
		hit_ctrl  ? {30'h00000000, counter_control_reg} :
		hit_flags ? {24'h000000, flags_reg} :
		hit_mask  ? {24'h000000, source_mask_reg} :
		hit_lvllo ? {24'h000000, level_low_reg} :
		hit_lvlhi ? {24'h000000, level_high_reg} :
		hit_serv  ? {28'h0000000, in_service_reg} :
		hit_istat ? {30'h00000000, ev_status_reg} :
		hit_imask ? {30'h00000000, ev_mask_reg} :
		RD_ZERO;
	assign prdata = rd ? rd_mux : RD_ZERO;

	////////////////////////////////////////////////////////////////////////
	// external pins
	// two synchroniser flops and one edge flop: a pin reaches its flag in about three cycles
	logic ext0_low;
	logic ext0_fall;
	logic ext1_low;
	logic ext1_fall;

	npiu_ext_line u_ext0 (
		.pclk     (pclk),
		.presetn  (presetn),
		.line_n   (ext_line_zero_n),
		.asserted (ext0_low),
		.fall     (ext0_fall)
	);

	npiu_ext_line u_ext1 (
		.pclk     (pclk),
		.presetn  (presetn),
		.line_n   (ext_line_one_n),
		.asserted (ext1_low),
		.fall     (ext1_fall)
	);

	////////////////////////////////////////////////////////////////////////
	// request flags
	logic               ext_zero_edge_sel;
	logic               ext_one_edge_sel;
	logic               flag_wr;
	logic               take_call;
	logic [NUM_SRC-1:0] vec_hit;
	logic [FLG_W-1:0]   hw_set;
	logic [FLG_W-1:0]   hw_clr;
	logic [FLG_W-1:0]   base;

	assign ext_zero_edge_sel = counter_control_reg[CTL_EDGE0];
	assign ext_one_edge_sel  = counter_control_reg[CTL_EDGE1];
	assign flag_wr           = wr & hit_flags;

	// one hot of the source being vectored this cycle
	always_comb begin
		vec_hit = '0;
		if (take_call) begin
			vec_hit[arb.grant_id] = 1'b1;
		end
	end

	// edge sets, rollover sets and peripheral done sets
	assign hw_set[FLG_EXT0] = ext_zero_edge_sel & ext0_fall;
	assign hw_set[FLG_CNT0] = cnt0_rollover;
	assign hw_set[FLG_EXT1] = ext_one_edge_sel & ext1_fall;
	assign hw_set[FLG_CNT1] = cnt1_rollover;
	assign hw_set[FLG_RX]   = uart_rx_set;
	assign hw_set[FLG_TX]   = uart_tx_set;
	assign hw_set[FLG_C2OV] = cnt2_overflow_set;
	assign hw_set[FLG_C2EX] = cnt2_external_set;

	// serial and third counter flags are left to software on a call
	assign hw_clr[FLG_EXT0] = ext_zero_edge_sel & vec_hit[SRC_EXT0];
	assign hw_clr[FLG_CNT0] = vec_hit[SRC_CNT0];
	assign hw_clr[FLG_EXT1] = ext_one_edge_sel & vec_hit[SRC_EXT1];
	assign hw_clr[FLG_CNT1] = vec_hit[SRC_CNT1];
	assign hw_clr[FLG_RX]   = 1'b0;
	assign hw_clr[FLG_TX]   = 1'b0;
	assign hw_clr[FLG_C2OV] = 1'b0;
	assign hw_clr[FLG_C2EX] = 1'b0;

	// a software write replaces the value; a hardware set in the same cycle wins
	assign base = flag_wr ? pwdata[FLG_W-1:0] : (flags_reg & ~hw_clr);

	always_comb begin
		flags_next = base | hw_set;
		// level mode: the pin owns the flag, a write lasts one cycle at most
		if (!ext_zero_edge_sel && !flag_wr) begin
			flags_next[FLG_EXT0] = ext0_low;
		end
		if (!ext_one_edge_sel && !flag_wr) begin
			flags_next[FLG_EXT1] = ext1_low;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// source requests, masks and levels
	logic [NUM_SRC-1:0] src_req;
	logic [NUM_SRC-1:0] src_enabled;
	logic               global_mask;

	assign src_req[SRC_EXT0] = flags_reg[FLG_EXT0];
	assign src_req[SRC_CNT0] = flags_reg[FLG_CNT0];
	assign src_req[SRC_EXT1] = flags_reg[FLG_EXT1];
	assign src_req[SRC_CNT1] = flags_reg[FLG_CNT1];
	assign src_req[SRC_UART] = flags_reg[FLG_RX] | flags_reg[FLG_TX];
	assign src_req[SRC_CNT2] = flags_reg[FLG_C2OV] | flags_reg[FLG_C2EX];

	assign global_mask = source_mask_reg[MSK_GLOBAL];
	// masks act at poll time so a mask change applies to held samples too
	assign src_enabled = sample_reg & source_mask_reg[NUM_SRC-1:0]
		& {NUM_SRC{global_mask}};

	assign arb.active     = src_enabled;
	assign arb.in_service = in_service_reg;

	generate
		for (genvar g = 0; g < NUM_SRC; g++) begin : g_lvl
			assign arb.level[g*LVL_W +: LVL_W] = {level_high_reg[g], level_low_reg[g]};
		end
	endgenerate

	npiu_resolver u_resolver (
		.arb (arb)
	);

	////////////////////////////////////////////////////////////////////////
	// poll and vector call
	logic call_allowed;
	logic ret_now;

	// the core holds these levels until the machine cycle boundary
	assign call_allowed = last_cycle & ~return_from_handler & ~mask_write_inst;
	// only fresh samples are polled, nothing older is kept
	assign take_call = sample_phase & sample_valid_reg & arb.grant_valid & call_allowed;
	// a pending return blocks calls, so a return and a call never share an edge
	assign ret_now   = sample_phase & last_cycle & return_from_handler;

	// return drops the highest active level, then a call adds its own
	always_comb begin
		in_service_next = in_service_reg;
		if (ret_now) begin
			for (int l = 0; l < NUM_LVL; l++) begin
				if (in_service_reg[l]) begin
					in_service_next = in_service_reg & ~(NUM_LVL'(1) << l);
				end
			end
		end
		if (take_call) begin
			in_service_next[arb.grant_level] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// event status, read clears, set wins
	logic [EV_W-1:0] ev_set;

	assign ev_set[EV_CALL] = take_call;
	assign ev_set[EV_RET]  = ret_now;
	assign ev_status_next  = ((rd && hit_istat) ? RST_EV : ev_status_reg) | ev_set;

	////////////////////////////////////////////////////////////////////////
	// registers
	// read-only and unmapped offsets simply drop the write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_control_reg <= RST_CTRL;
			source_mask_reg     <= RST_BYTE;
			level_low_reg       <= RST_BYTE;
			level_high_reg      <= RST_BYTE;
			ev_mask_reg         <= RST_EV;
		end else if (wr) begin
			if (hit_ctrl) begin
				counter_control_reg <= pwdata[1:0];
			end
			if (hit_mask) begin
				source_mask_reg <= pwdata[7:0];
			end
			if (hit_lvllo) begin
				level_low_reg <= pwdata[7:0];
			end
			if (hit_lvlhi) begin
				level_high_reg <= pwdata[7:0];
			end
			if (hit_imask) begin
				ev_mask_reg <= pwdata[EV_W-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_reg      <= RST_BYTE;
			in_service_reg <= RST_SERV;
			ev_status_reg  <= RST_EV;
		end else begin
			flags_reg      <= flags_next;
			in_service_reg <= in_service_next;
			ev_status_reg  <= ev_status_next;
		end
	end

	// samples taken at sample_phase are polled at the next one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_reg       <= '0;
			sample_valid_reg <= 1'b0;
		end else if (sample_phase) begin
			sample_reg       <= src_req;
			sample_valid_reg <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			call_reg <= 1'b0;
			id_reg   <= RST_ID;
			lvl_reg  <= RST_LVL;
		end else begin
			call_reg <= take_call;
			if (take_call) begin
				id_reg  <= arb.grant_id;
				lvl_reg <= arb.grant_level;
			end
		end
	end

	assign hw_vector_call = call_reg;
	assign vector_id      = id_reg;
	assign vector_level   = lvl_reg;
	assign irq            = |(ev_status_reg & ev_mask_reg);
endmodule

// ---- verif/npiu_props.sv ----
// concurrent checks on the vector call side of the interrupt unit
// assumes one clock domain; bound to npiu_top from the bench
`timescale 1ns/10ps
module npiu_props
	import npiu_pkg::*;
(
	input wire logic                        pclk,
	input wire logic                        presetn,
	input wire logic                        sample_phase,
	input wire logic                        last_cycle,
	input wire logic                        return_from_handler,
	input wire logic                        mask_write_inst,
	input wire logic                        hw_vector_call,
	input wire logic [npiu_pkg::ID_W-1:0]   vector_id,
	input wire logic [npiu_pkg::LVL_W-1:0]  vector_level
);
	import npiu_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	// shadow of the in-service levels: calls land one cycle behind the design, returns on the same edge
	logic [3:0] ins_reg;
	logic [3:0] top_bit;
	logic [1:0] top_lvl;
	assign top_bit = ins_reg[3] ? 4'h8 : ins_reg[2] ? 4'h4 :
		ins_reg[1] ? 4'h2 : ins_reg[0] ? 4'h1 : 4'h0;
	assign top_lvl = ins_reg[3] ? 2'h3 : ins_reg[2] ? 2'h2 : ins_reg[1] ? 2'h1 : 2'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ins_reg <= 4'h0;
		else if (hw_vector_call)
			ins_reg[vector_level] <= 1'b1;
		else if (sample_phase && last_cycle && return_from_handler)
			ins_reg <= ins_reg & ~top_bit;
	end
	////////////////////////////////////////////////////////////////
	a_call_on_phase: assert property (hw_vector_call |-> $past(sample_phase))
		else $error("call not after a sample phase");
	a_call_single: assert property (hw_vector_call |=> !hw_vector_call)
		else $error("call longer than one cycle");
	a_call_last_cyc: assert property (hw_vector_call |-> $past(last_cycle))
		else $error("call outside last cycle");
	a_call_not_ret: assert property (hw_vector_call |->
		!$past(return_from_handler) && !$past(mask_write_inst))
		else $error("call after return or mask write");
	a_vector_held: assert property (!hw_vector_call |-> $stable(vector_id) && $stable(vector_level))
		else $error("vector changed without call");
	a_id_valid: assert property (hw_vector_call |-> vector_id <= 3'h5)
		else $error("vector id out of range");
	a_preempt_higher: assert property (hw_vector_call |->
		ins_reg == 4'h0 || vector_level > top_lvl)
		else $error("call at level not above service");
	a_top_final: assert property (hw_vector_call |-> !ins_reg[3])
		else $error("call while level three in service");
endmodule

// ---- verif/npiu_core_model.sv ----
// model of the processor core: machine cycle phase and handler return
// assumes the bench asks for returns and stalls by level inputs
`timescale 1ns/10ps
module npiu_core_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic stall_req,
	input wire logic mw_req,
	input wire logic ret_req,
	output logic     sample_phase,
	output logic     last_cycle,
	output logic     return_from_handler,
	output logic     mask_write_inst
);
	logic [1:0] cnt_reg;
	// a stall keeps the instruction from its last cycle
	assign last_cycle      = !stall_req;
	assign mask_write_inst = mw_req;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg             <= 2'h0;
			sample_phase        <= 1'b0;
			return_from_handler <= 1'b0;
		end else begin
			cnt_reg      <= cnt_reg + 2'h1;
			sample_phase <= (cnt_reg == 2'h3);
			// return held until a deciding phase takes it
			if (ret_req)
				return_from_handler <= 1'b1;
			else if (sample_phase && last_cycle)
				return_from_handler <= 1'b0;
		end
	end
endmodule

// ---- verif/nested_priority_interrupt_unit_tb.sv ----
// self-checking bench: apb register access, pins, pulses, core model
// assumes npiu_top and npiu_core_model; the checker is bound below
`timescale 1ns/10ps
module nested_priority_interrupt_unit_tb;
	import npiu_pkg::*;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0, prdata, rq = 32'h0;
	logic              pready, pslverr, re = 1'b0;
	logic              x0_n = 1'b1, x1_n = 1'b1;
	logic [5:0]        setp = 6'h00;
	logic              stall = 1'b0, mw = 1'b0, ret_req = 1'b0;
	logic              sph, lastc, rfh, mwi, call, irq;
	logic [ID_W-1:0]   vector_id;
	logic [LVL_W-1:0]  vector_level;
	int                error_cnt = 0, check_count = 0, ncall = 0, seen = 0, cyc = 0;
	always #2.5 pclk = ~pclk;
	npiu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_line_zero_n(x0_n), .ext_line_one_n(x1_n),
		.cnt0_rollover(setp[0]), .cnt1_rollover(setp[1]), .uart_rx_set(setp[2]),
		.uart_tx_set(setp[3]), .cnt2_overflow_set(setp[4]), .cnt2_external_set(setp[5]),
		.sample_phase(sph), .last_cycle(lastc), .return_from_handler(rfh),
		.mask_write_inst(mwi), .hw_vector_call(call), .vector_id(vector_id),
		.vector_level(vector_level), .irq(irq));
	npiu_core_model core (.pclk(pclk), .presetn(presetn), .stall_req(stall), .mw_req(mw),
		.ret_req(ret_req), .sample_phase(sph), .last_cycle(lastc),
		.return_from_handler(rfh), .mask_write_inst(mwi));
	////////////////////////////////////////////////////////////////
	always @(posedge pclk) begin
		if (psel && penable && pready) begin
			rq <= prdata;
			re <= pslverr;
		end
		if (call === 1'b1)
			ncall <= ncall + 1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end
	task conclude;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("rdata", rq, e);
	endtask
	task wcall(input logic [2:0] id, input logic [1:0] lv);
		repeat (80) if (ncall == seen) @(posedge pclk);
		#1;
		chk("calls", ncall, seen + 1);
		seen = ncall;
		chk("id", {29'h0, vector_id}, {29'h0, id});
		chk("lvl", {30'h0, vector_level}, {30'h0, lv});
	endtask
	task nocall;
		repeat (24) @(posedge pclk);
		#1;
		chk("nocall", ncall, seen);
	endtask
	task ret;
		@(posedge pclk) ret_req <= 1'b1;
		@(posedge pclk) ret_req <= 1'b0;
		// let the core raise its return before waiting for it to be taken
		@(posedge pclk);
		repeat (20) if (rfh) @(posedge pclk);
	endtask
	task pulse(input int i);
		@(posedge pclk) setp[i] <= 1'b1;
		@(posedge pclk) setp[i] <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) rd(8'(i * 4), 32'h0);
		rd(8'h20, 32'h0);
		chk("slverr", {31'h0, re}, 32'h1);
		$display("test regs done");
		wr(OFS_MASK, 32'hBF);
		wr(OFS_IMASK, 32'h1);
		wr(OFS_CTRL, 32'h3);
		wr(OFS_FLAGS, 32'hFF);
		for (int i = 0; i < 5; i++) begin
			wcall(3'(i), 2'h0);
			ret();
		end
		wcall(3'h4, 2'h0);
		rd(OFS_FLAGS, 32'hF0);
		wr(OFS_MASK, 32'hAF);
		ret();
		wcall(3'h5, 2'h0);
		wr(OFS_FLAGS, 32'h0);
		ret();
		nocall();
		chk("irq", {31'h0, irq}, 32'h1);
		rd(OFS_ISTAT, 32'h3);
		chk("irq", {31'h0, irq}, 32'h0);
		$display("test order done");
		wr(OFS_IMASK, 32'h0);
		wr(OFS_MASK, 32'h3F);
		wr(OFS_FLAGS, 32'h2);
		nocall();
		wr(OFS_MASK, 32'hBD);
		nocall();
		wr(OFS_MASK, 32'hBF);
		wcall(3'h1, 2'h0);
		chk("irq", {31'h0, irq}, 32'h0);
		ret();
		@(posedge pclk) stall <= 1'b1;
		wr(OFS_FLAGS, 32'h2);
		nocall();
		wr(OFS_FLAGS, 32'h0);
		repeat (8) @(posedge pclk);
		@(posedge pclk) stall <= 1'b0;
		nocall();
		@(posedge pclk) mw <= 1'b1;
		wr(OFS_FLAGS, 32'h2);
		nocall();
		@(posedge pclk) mw <= 1'b0;
		wcall(3'h1, 2'h0);
		ret();
		$display("test masks done");
		wr(OFS_LVLLO, 32'h08);
		wr(OFS_FLAGS, 32'h0A);
		wcall(3'h3, 2'h1);
		nocall();
		wr(OFS_LVLLO, 32'h0A);
		nocall();
		wr(OFS_LVLHI, 32'h02);
		wcall(3'h1, 2'h3);
		rd(OFS_SERV, 32'hA);
		wr(OFS_LVLHI, 32'h0A);
		wr(OFS_FLAGS, 32'h08);
		nocall();
		ret();
		wcall(3'h3, 2'h3);
		ret();
		ret();
		rd(OFS_SERV, 32'h0);
		wr(OFS_LVLLO, 32'h0);
		wr(OFS_LVLHI, 32'h0);
		$display("test levels done");
		wr(OFS_CTRL, 32'h0);
		@(posedge pclk) x1_n <= 1'b0;
		wcall(3'h2, 2'h0);
		ret();
		wcall(3'h2, 2'h0);
		@(posedge pclk) x1_n <= 1'b1;
		repeat (8) @(posedge pclk);
		ret();
		nocall();
		wr(OFS_CTRL, 32'h1);
		@(posedge pclk) x0_n <= 1'b0;
		repeat (4) @(posedge pclk);
		@(posedge pclk) x0_n <= 1'b1;
		wcall(3'h0, 2'h0);
		rd(OFS_FLAGS, 32'h0);
		ret();
		pulse(3);
		wcall(3'h4, 2'h0);
		rd(OFS_FLAGS, 32'h20);
		wr(OFS_FLAGS, 32'h0);
		ret();
		pulse(1);
		wcall(3'h3, 2'h0);
		rd(OFS_FLAGS, 32'h0);
		ret();
		pulse(5);
		wcall(3'h5, 2'h0);
		wr(OFS_FLAGS, 32'h0);
		ret();
		pulse(0);
		pulse(4);
		wcall(3'h1, 2'h0);
		rd(OFS_FLAGS, 32'h40);
		wr(OFS_FLAGS, 32'h0);
		ret();
		pulse(2);
		wcall(3'h4, 2'h0);
		rd(OFS_FLAGS, 32'h10);
		wr(OFS_FLAGS, 32'h0);
		ret();
		$display("test pins done");
		conclude();
	end
endmodule

bind npiu_top npiu_props u_props (.pclk(pclk), .presetn(presetn), .sample_phase(sample_phase),
	.last_cycle(last_cycle), .return_from_handler(return_from_handler),
	.mask_write_inst(mask_write_inst), .hw_vector_call(hw_vector_call),
	.vector_id(vector_id), .vector_level(vector_level));
